//--- common/pin_mux_pkg.sv
package pin_mux_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATE = 8'h04;
    localparam logic [7:0] ADDR_GPIO_OUT = 8'h08;
    localparam logic [7:0] ADDR_GPIO_IN = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

    // ------------------------------------------------------------------
    // Command field layout of the configuration register
    // ------------------------------------------------------------------
    localparam int SEL_LSB = 0;
    localparam int SWITCH_BIT = 4;
    localparam int FUNC_LSB = 8;

    localparam logic [1:0] SEL_POSITION = 2'h0;
    localparam logic [1:0] SEL_ERROR = 2'h1;
    localparam logic [1:0] SEL_RESET = 2'h2;
    localparam logic [1:0] SEL_USER = 2'h3;

    localparam logic [1:0] FUNC_IN = 2'h0;
    localparam logic [1:0] FUNC_OUT = 2'h1;
    localparam logic [1:0] FUNC_EVENT = 2'h2;

    // ------------------------------------------------------------------
    // State readback bit positions and reset values
    // ------------------------------------------------------------------
    localparam int ST_EN_LSB = 0;
    localparam int ST_FUNC_LSB = 4;
    localparam int ST_DIR_OUT = 6;
    localparam int ST_RST_CHOICE = 7;
    localparam logic [3:0] EN_RESET = 4'hF;
    localparam logic [1:0] FUNC_RESET = 2'h0;

    // Interrupt status bits: event inputs b, c and d.
    localparam int IRQ_EVB = 0;
    localparam int IRQ_EVC = 1;
    localparam int IRQ_EVD = 2;
    localparam int IRQ_W = 3;

    // Reset pulse width in cycles of the 40 ns clock.
    localparam int RESET_PULSE_NS = 1000;
    localparam int CLK_NS = 40;
    localparam int RESET_PULSE_CYC = RESET_PULSE_NS / CLK_NS;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : pin_mux_pkg

//--- core/multiplexed_io_pin_selector.sv
`timescale 1ns/1ps
// How it works
// - Selector field picks pin: position 0, error 1, reset 2, user 3.
// - Switch field 0 disables mux control, 1 enables it.
// - Function field for user pin: 0 input, 1 output, 2 event.
// - Function field ignored when any pin but the user pin is selected.
// - Position pin enabled carries the position valid indicator.
// - Position pin disabled carries event output c.
// - Error pin enabled goes high on any receiver error.
// - Error pin disabled is event input d.
// - Reset pin enabled outputs an active-low pulse on board reset.
// - Reset pin disabled is event input b or c, by product variant.
// - User enabled input: general input; shared pin keeps last reset choice.
// - User enabled output: general output; shared pin keeps last choice.
// - User event: user pin is event b; shared pin forced to reset pulse.
// - Remembered reset choice becomes reset pulse after a user event choice.
// - User disabled: general pin in last direction; shared pin is event b or c, by product variant.
// - Remembered user direction becomes input after a user event choice.
// - Each pin keeps its own setting; configuring one leaves others, except that leaving user event sets the remembered reset choice.
module multiplexed_io_pin_selector
    import pin_mux_pkg::*;
#(
    parameter bit VARIANT_B = 1'b0 // High: reset pin event is input c.
)
(
    input wire logic clk, // 25 MHz clock.
    input wire logic reset_n, // Asynchronous active-low reset.
    input wire logic [7:0] s_axil_awaddr, // Write address.
    input wire logic s_axil_awvalid, // Write address valid.
    output logic s_axil_awready, // Write address ready.
    input wire logic [31:0] s_axil_wdata, // Write data.
    input wire logic [3:0] s_axil_wstrb, // Write strobes.
    input wire logic s_axil_wvalid, // Write data valid.
    output logic s_axil_wready, // Write data ready.
    output logic [1:0] s_axil_bresp, // Write response.
    output logic s_axil_bvalid, // Write response valid.
    input wire logic s_axil_bready, // Write response ready.
    input wire logic [7:0] s_axil_araddr, // Read address.
    input wire logic s_axil_arvalid, // Read address valid.
    output logic s_axil_arready, // Read address ready.
    output logic [31:0] s_axil_rdata, // Read data.
    output logic [1:0] s_axil_rresp, // Read response.
    output logic s_axil_rvalid, // Read data valid.
    input wire logic s_axil_rready, // Read data ready.
    input wire logic position_valid, // Position valid indicator.
    input wire logic rx_error, // Any receiver error condition.
    input wire logic event_output_c, // Event output c source.
    input wire logic board_reset, // Board reset request pulse.
    output logic position_valid_out, // Position pin drive.
    input wire logic error_indicator_in, // Error pin level in.
    output logic error_indicator_out, // Error pin drive.
    output logic error_indicator_oe_n, // Error pin enable, low drives.
    input wire logic reset_pulse_in, // Reset pin level in.
    output logic reset_pulse_pin, // Reset pin drive.
    output logic reset_pulse_oe_n, // Reset pin enable, low drives.
    input wire logic user_general_in, // User pin level in.
    output logic user_general_pin, // User pin drive.
    output logic user_general_oe_n, // User pin enable, low drives.
    output logic event_input_b, // Event input b to the receiver.
    output logic event_input_c, // Event input c to the receiver.
    output logic event_input_d, // Event input d to the receiver.
    output logic irq // Level interrupt.
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Bus slave and configuration state
    // ------------------------------------------------------------------
    logic aw_held_r, aw_held_nxt;
    logic [7:0] aw_addr_r, aw_addr_nxt;
    logic w_held_r, w_held_nxt;
    logic [31:0] w_data_r, w_data_nxt;
    logic [3:0] w_strb_r, w_strb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    logic [3:0] en_r, en_nxt;
    logic [1:0] func_r, func_nxt;
    logic dir_out_r, dir_out_nxt;
    logic rst_choice_r, rst_choice_nxt;
    logic gpio_out_r, gpio_out_nxt;
    logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
    logic [IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
    logic [IRQ_W-1:0] ev_prev_r, ev_prev_nxt;
    logic [7:0] pulse_cnt_r, pulse_cnt_nxt;

    logic do_write;
    logic [IRQ_W-1:0] ev_now;
    logic [IRQ_W-1:0] ev_rise;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = (a == ADDR_CONFIG) || (a == ADDR_STATE) ||
            (a == ADDR_GPIO_OUT) || (a == ADDR_GPIO_IN) ||
            (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK);
    endfunction : addr_ok

    assign do_write = aw_held_r && w_held_r && !bvalid_r;
    assign s_axil_awready = !aw_held_r;
    assign s_axil_wready = !w_held_r;
    assign s_axil_arready = !rvalid_r;
    assign ev_now = {event_input_d, event_input_c, event_input_b};
    assign ev_rise = ev_now & ~ev_prev_r;

    always_comb
    begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt = w_held_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        en_nxt = en_r;
        func_nxt = func_r;
        dir_out_nxt = dir_out_r;
        rst_choice_nxt = rst_choice_r;
        gpio_out_nxt = gpio_out_r;
        irq_mask_nxt = irq_mask_r;
        irq_stat_nxt = irq_stat_r;
        ev_prev_nxt = ev_now;
        pulse_cnt_nxt = pulse_cnt_r;
        if (s_axil_awvalid && !aw_held_r)
        begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axil_awaddr;
        end
        if (s_axil_wvalid && !w_held_r)
        begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axil_wdata;
            w_strb_nxt = s_axil_wstrb;
        end
        if (bvalid_r && s_axil_bready)
        begin
            bvalid_nxt = 1'b0;
        end
        if (do_write)
        begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = addr_ok(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
            if (aw_addr_r == ADDR_CONFIG && w_strb_r[0] && w_strb_r[1])
            begin : cfg
                logic [1:0] sel;
                logic sw;
                logic [1:0] fn;
                sel = w_data_r[SEL_LSB +: 2];
                sw = w_data_r[SWITCH_BIT];
                fn = w_data_r[FUNC_LSB +: 2];
                en_nxt[sel] = sw;
                if (sel == SEL_RESET)
                begin
                    rst_choice_nxt = sw;
                end
                // function decode for the user pin
                if (sel == SEL_USER && sw && fn != 2'h3)
                begin
                    if (func_r == FUNC_EVENT)
                    begin
                        rst_choice_nxt = 1'b1;
                        dir_out_nxt = 1'b0;
                    end
                    func_nxt = fn;
                    if (fn == FUNC_IN || fn == FUNC_OUT)
                    begin
                        dir_out_nxt = (fn == FUNC_OUT);
                    end
                end
                if (sel == SEL_USER && !sw && func_r == FUNC_EVENT)
                begin
                    dir_out_nxt = 1'b0;
                    rst_choice_nxt = 1'b1;
                    func_nxt = FUNC_IN;
                end
            end
            if (aw_addr_r == ADDR_GPIO_OUT && w_strb_r[0])
            begin
                gpio_out_nxt = w_data_r[0];
            end
            if (aw_addr_r == ADDR_IRQ_MASK && w_strb_r[0])
            begin
                irq_mask_nxt = w_data_r[IRQ_W-1:0];
            end
            if (aw_addr_r == ADDR_IRQ_STATUS && w_strb_r[0])
            begin
                irq_stat_nxt = irq_stat_r & ~w_data_r[IRQ_W-1:0];
            end
        end
        // Events set after the clear so that a set wins.
        irq_stat_nxt = irq_stat_nxt | ev_rise;
        if (s_axil_arvalid && !rvalid_r)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = addr_ok(s_axil_araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_nxt = 32'h0000_0000;
            unique case (s_axil_araddr)
                ADDR_STATE:
                begin
                    rdata_nxt[ST_EN_LSB +: 4] = en_r;
                    rdata_nxt[ST_FUNC_LSB +: 2] = func_r;
                    rdata_nxt[ST_DIR_OUT] = dir_out_r;
                    rdata_nxt[ST_RST_CHOICE] = rst_choice_r;
                end
                ADDR_GPIO_OUT: rdata_nxt[0] = gpio_out_r;
                ADDR_GPIO_IN: rdata_nxt[0] = user_general_in;
                ADDR_IRQ_STATUS: rdata_nxt[IRQ_W-1:0] = irq_stat_r;
                ADDR_IRQ_MASK: rdata_nxt[IRQ_W-1:0] = irq_mask_r;
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        else if (rvalid_r && s_axil_rready)
        begin
            rvalid_nxt = 1'b0;
        end
        // active-low pulse timer on board reset
        if (board_reset)
        begin
            pulse_cnt_nxt = 8'(RESET_PULSE_CYC);
        end
        else if (pulse_cnt_r != 8'h00)
        begin
            pulse_cnt_nxt = pulse_cnt_r - 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
            // all pins enabled, user function input
            en_r <= EN_RESET;
            func_r <= FUNC_RESET;
            dir_out_r <= 1'b0;
            rst_choice_r <= 1'b1;
            gpio_out_r <= 1'b0;
            irq_stat_r <= '0;
            irq_mask_r <= '0;
            ev_prev_r <= '0;
            pulse_cnt_r <= 8'(RESET_PULSE_CYC);
        end
        else
        begin
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r <= w_held_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            en_r <= en_nxt;
            func_r <= func_nxt;
            dir_out_r <= dir_out_nxt;
            rst_choice_r <= rst_choice_nxt;
            gpio_out_r <= gpio_out_nxt;
            irq_stat_r <= irq_stat_nxt;
            irq_mask_r <= irq_mask_nxt;
            ev_prev_r <= ev_prev_nxt;
            pulse_cnt_r <= pulse_cnt_nxt;
        end
    end

    assign s_axil_bvalid = bvalid_r;
    assign s_axil_bresp = bresp_r;
    assign s_axil_rvalid = rvalid_r;
    assign s_axil_rdata = rdata_r;
    assign s_axil_rresp = rresp_r;
    assign irq = |(irq_stat_r & irq_mask_r);

    // ------------------------------------------------------------------
    // Pin routing
    // ------------------------------------------------------------------
    logic user_event;
    logic shared_is_reset;

    assign user_event = en_r[SEL_USER] && func_r == FUNC_EVENT;

    // The shared pin follows the user pin first, then its own choice.
    always_comb
    begin
        if (user_event)
        begin
            // event mode forces reset pulse on the shared pin
            shared_is_reset = 1'b1;
        end
        else if (!en_r[SEL_USER])
        begin
            // user disabled makes shared pin event b or c by variant
            shared_is_reset = 1'b0;
        end
        else
        begin
            // input mode keeps last reset choice
            // output mode keeps last reset choice
            shared_is_reset = rst_choice_r;
        end
    end

    always_comb
    begin
        position_valid_out = en_r[SEL_POSITION] ? position_valid
                                                : event_output_c;
        // error pin high on receiver error
        // disabled error pin becomes an input
        error_indicator_out = rx_error;
        error_indicator_oe_n = !en_r[SEL_ERROR];
        event_input_d = en_r[SEL_ERROR] ? 1'b0 : error_indicator_in;
        reset_pulse_pin = (pulse_cnt_r == 8'h00);
        reset_pulse_oe_n = !shared_is_reset;
        // user pin as general input or output
        user_general_pin = gpio_out_r;
        user_general_oe_n = user_event || !dir_out_r;
        // disabled reset pin is event b or c by variant
        // user pin is event b in event mode
        if (user_event)
        begin
            event_input_b = user_general_in;
            event_input_c = 1'b0;
        end
        else if (!shared_is_reset && VARIANT_B)
        begin
            event_input_b = 1'b0;
            event_input_c = reset_pulse_in;
        end
        else
        begin
            event_input_b = shared_is_reset ? 1'b0 : reset_pulse_in;
            event_input_c = 1'b0;
        end
    end

endmodule : multiplexed_io_pin_selector

//--- verif/pin_mux_sva.sv
`timescale 1ns/1ps
module pin_mux_sva
#(
    parameter bit VARIANT_B = 1'b0 // Reset pin event choice.
)
(
    input logic clk, // In.
    input logic reset_n, // In.
    input logic s_axil_awvalid, // In.
    input logic s_axil_awready, // In.
    input logic s_axil_wvalid, // In.
    input logic s_axil_wready, // In.
    input logic [1:0] s_axil_bresp, // In.
    input logic s_axil_bvalid, // In.
    input logic s_axil_bready, // In.
    input logic s_axil_arvalid, // In.
    input logic [31:0] s_axil_rdata, // In.
    input logic s_axil_rvalid, // In.
    input logic s_axil_rready, // In.
    input logic position_valid, // In.
    input logic event_output_c, // In.
    input logic position_valid_out, // In.
    input logic rx_error, // In.
    input logic error_indicator_out, // In.
    input logic error_indicator_oe_n, // In.
    input logic error_indicator_in, // In.
    input logic event_input_d, // In.
    input logic board_reset, // In.
    input logic reset_pulse_in, // In.
    input logic reset_pulse_pin, // In.
    input logic reset_pulse_oe_n, // In.
    input logic event_input_b // In.
);
    // ------
    // Checks
    // ------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence wr_taken;
        s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
    endsequence
    sequence pulse_low;
        (!reset_pulse_pin) [*8];
    endsequence

    a_pv_route: assert property (
        position_valid_out == position_valid ||
        position_valid_out == event_output_c)
        else $error("position pin bad");
    a_err_drive: assert property (
        !error_indicator_oe_n |-> error_indicator_out == rx_error)
        else $error("error pin bad");
    a_evd_route: assert property (
        error_indicator_oe_n |-> event_input_d == error_indicator_in)
        else $error("event d bad");
    a_evb_route: assert property (
        reset_pulse_oe_n && !VARIANT_B |-> event_input_b == reset_pulse_in)
        else $error("event b bad");
    a_rst_release: assert property (
        $rose(reset_n) |-> pulse_low)
        else $error("no reset pulse");
    a_board_pulse: assert property (
        $rose(board_reset) |-> ##[1:3] pulse_low)
        else $error("no board pulse");
    a_b_latency: assert property (wr_taken |-> ##[1:3] s_axil_bvalid)
        else $error("write response late");
    a_b_hold: assert property (
        s_axil_bvalid && !s_axil_bready |=>
        s_axil_bvalid && $stable(s_axil_bresp))
        else $error("bresp dropped");
    a_r_latency: assert property (
        s_axil_arvalid && !s_axil_rvalid |=> s_axil_rvalid)
        else $error("read data late");
    a_r_hold: assert property (
        s_axil_rvalid && !s_axil_rready |=>
        s_axil_rvalid && $stable(s_axil_rdata))
        else $error("rdata dropped");
endmodule : pin_mux_sva

bind multiplexed_io_pin_selector pin_mux_sva #(.VARIANT_B(VARIANT_B)) u_sva (
    .clk, .reset_n, .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid,
    .s_axil_wready, .s_axil_bresp, .s_axil_bvalid, .s_axil_bready,
    .s_axil_arvalid, .s_axil_rdata, .s_axil_rvalid, .s_axil_rready,
    .position_valid, .event_output_c, .position_valid_out, .rx_error,
    .error_indicator_out, .error_indicator_oe_n, .error_indicator_in,
    .event_input_d, .board_reset, .reset_pulse_in, .reset_pulse_pin,
    .reset_pulse_oe_n, .event_input_b
);

//--- verif/board_model.sv
`timescale 1ns/1ps
module board_model
(
    input logic error_indicator_out, // Drive.
    input logic error_indicator_oe_n, // Enable, low.
    input logic reset_pulse_pin, // Drive.
    input logic reset_pulse_oe_n, // Enable, low.
    input logic user_general_pin, // Drive.
    input logic user_general_oe_n, // Enable, low.
    input logic ext_err, // Board level.
    input logic ext_rst, // Board level.
    input logic ext_user, // Board level.
    output logic error_indicator_in, // Pin level.
    output logic reset_pulse_in, // Pin level.
    output logic user_general_in // Pin level.
);
    // ----------
    // Board pins
    // ----------
    // The board yields while the device drives.
    // error pin event
    assign error_indicator_in = error_indicator_oe_n ? ext_err
                                                     : error_indicator_out;
    assign reset_pulse_in = reset_pulse_oe_n ? ext_rst : reset_pulse_pin;
    assign user_general_in = user_general_oe_n ? ext_user : user_general_pin;
endmodule : board_model

//--- verif/multiplexed_io_pin_selector_bench.sv
`timescale 1ns/1ps
module multiplexed_io_pin_selector_bench;
    import pin_mux_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0;
    logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
    logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
    logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
    logic [31:0] s_axil_wdata = 32'h0000_0000, s_axil_rdata, rd, v;
    logic [3:0] s_axil_wstrb = 4'hF;
    logic position_valid = 1'b0, rx_error = 1'b0, event_output_c = 1'b0;
    logic board_reset = 1'b0, ext_err = 1'b0, ext_rst = 1'b0;
    logic ext_user = 1'b0, s_axil_awready, s_axil_wready, s_axil_bvalid;
    logic s_axil_arready, s_axil_rvalid, position_valid_out, irq;
    logic error_indicator_in, error_indicator_out, error_indicator_oe_n;
    logic reset_pulse_in, reset_pulse_pin, reset_pulse_oe_n;
    logic user_general_in, user_general_pin, user_general_oe_n;
    logic event_input_b, event_input_c, event_input_d;
    logic [1:0] s_axil_bresp, s_axil_rresp, resp;
    int n_errors = 0, checks_done = 0, cyc = 0;
    int seed = 32'hdabd_08d9;

    multiplexed_io_pin_selector #(.VARIANT_B(1'b0)) DUT (
        .clk, .reset_n, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
        .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready,
        .s_axil_bresp, .s_axil_bvalid, .s_axil_bready, .s_axil_araddr,
        .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
        .s_axil_rvalid, .s_axil_rready, .position_valid, .rx_error,
        .event_output_c, .board_reset, .position_valid_out,
        .error_indicator_in, .error_indicator_out, .error_indicator_oe_n,
        .reset_pulse_in, .reset_pulse_pin, .reset_pulse_oe_n,
        .user_general_in, .user_general_pin, .user_general_oe_n,
        .event_input_b, .event_input_c, .event_input_d, .irq
    );
    board_model u_board (
        .error_indicator_out, .error_indicator_oe_n, .reset_pulse_pin,
        .reset_pulse_oe_n, .user_general_pin, .user_general_oe_n, .ext_err,
        .ext_rst, .ext_user, .error_indicator_in, .reset_pulse_in,
        .user_general_in
    );

    always #20 clk = ~clk;

    // -------
    // Helpers
    // -------
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, s);
        checks_done++;
        if (e !== s)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, s);
            n_errors++;
        end
    endtask : chk

    task automatic chkb(input string nm, input logic e, s);
        chk(nm, {31'h0, e}, {31'h0, s});
    endtask : chkb

    function automatic logic [31:0] cfg(input logic [1:0] s,
        input logic w, input logic [1:0] f);
        cfg = 32'h0000_0000;
        cfg[SEL_LSB+:2] = s;
        cfg[SWITCH_BIT] = w;
        cfg[FUNC_LSB+:2] = f;
    endfunction : cfg

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wready) s_axil_wvalid <= 1'b0;
        end while (s_axil_bvalid !== 1'b1);
        resp = s_axil_bresp;
        s_axil_bready <= 1'b0;
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axil_arready) s_axil_arvalid <= 1'b0;
        end while (s_axil_rvalid !== 1'b1);
        rd = s_axil_rdata;
        resp = s_axil_rresp;
        s_axil_rready <= 1'b0;
    endtask : rdr

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : idle

    task automatic rnd();
        @(posedge clk);
        v = $random(seed);
        {ext_user, ext_rst, ext_err} <= v[5:3];
        {rx_error, event_output_c, position_valid} <= v[2:0];
        @(negedge clk);
    endtask : rnd

    // ---------
    // Scenarios
    // ---------
    initial
    begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chkb("pulse pin", 1'b0, reset_pulse_pin);
        chkb("pulse oe", 1'b0, reset_pulse_oe_n);
        idle(2);
        rdr(ADDR_STATE);
        chk("state", 32'h0000_000F, rd & 32'h0000_007F);
        rdr(8'h20);
        chk("unmapped", 32'(RESP_SLVERR), 32'(resp));
        idle(30);
        chkb("pulse end", 1'b1, reset_pulse_pin);
        $display("test reset done");
        repeat (6)
        begin
            rnd();
            chkb("pv out", position_valid, position_valid_out);
            chkb("err out", rx_error, error_indicator_out);
            chkb("err oe", 1'b0, error_indicator_oe_n);
        end
        wr(ADDR_CONFIG, cfg(SEL_POSITION, 1'b0, FUNC_EVENT));
        repeat (6)
        begin
            rnd();
            chkb("pv event", event_output_c, position_valid_out);
        end
        rdr(ADDR_STATE);
        chk("func kept", 32'h0000_000E, rd & 32'h0000_007F);
        $display("test position done");
        wr(ADDR_CONFIG, cfg(SEL_ERROR, 1'b0, FUNC_OUT));
        repeat (4)
        begin
            rnd();
            chkb("ev d", ext_err, event_input_d);
            chkb("err off", 1'b1, error_indicator_oe_n);
        end
        @(posedge clk);
        ext_err <= 1'b0;
        wr(ADDR_IRQ_MASK, 32'h0000_0000);
        wr(ADDR_IRQ_STATUS, 32'h0000_0007);
        @(posedge clk);
        ext_err <= 1'b1;
        idle(2);
        chkb("irq masked", 1'b0, irq);
        rdr(ADDR_IRQ_STATUS);
        chk("status", 32'h0000_0004, rd & 32'h0000_0007);
        wr(ADDR_IRQ_MASK, 32'h0000_0004);
        idle(1);
        chkb("irq on", 1'b1, irq);
        wr(ADDR_IRQ_STATUS, 32'h0000_0004);
        idle(1);
        chkb("irq off", 1'b0, irq);
        $display("test error pin done");
        wr(ADDR_CONFIG, cfg(SEL_RESET, 1'b0, FUNC_IN));
        repeat (4)
        begin
            rnd();
            chkb("ev b", ext_rst, event_input_b);
            chkb("rst off", 1'b1, reset_pulse_oe_n);
        end
        wr(ADDR_CONFIG, cfg(SEL_RESET, 1'b1, FUNC_IN));
        @(posedge clk);
        board_reset <= 1'b1;
        @(posedge clk);
        board_reset <= 1'b0;
        idle(3);
        chkb("board pulse", 1'b0, reset_pulse_pin);
        chkb("board oe", 1'b0, reset_pulse_oe_n);
        idle(30);
        chkb("board end", 1'b1, reset_pulse_pin);
        $display("test reset pin done");
        wr(ADDR_CONFIG, cfg(SEL_USER, 1'b1, FUNC_OUT));
        v = $random(seed);
        wr(ADDR_GPIO_OUT, {31'h0, v[0]});
        idle(1);
        chkb("user oe", 1'b0, user_general_oe_n);
        chkb("user out", v[0], user_general_pin);
        chkb("shared out", 1'b0, reset_pulse_oe_n);
        wr(ADDR_CONFIG, cfg(SEL_USER, 1'b1, FUNC_IN));
        idle(1);
        chkb("user in oe", 1'b1, user_general_oe_n);
        rdr(ADDR_GPIO_IN);
        chkb("gpio in", ext_user, rd[0]);
        wr(ADDR_CONFIG, cfg(SEL_RESET, 1'b0, FUNC_IN));
        wr(ADDR_CONFIG, cfg(SEL_USER, 1'b1, FUNC_EVENT));
        repeat (4)
        begin
            rnd();
            chkb("user ev", ext_user, event_input_b);
            chkb("forced", 1'b0, reset_pulse_oe_n);
        end
        wr(ADDR_CONFIG, cfg(SEL_USER, 1'b0, FUNC_IN));
        rdr(ADDR_STATE);
        chk("remembered", 32'h0000_0080, rd & 32'h0000_00C0);
        rnd();
        chkb("dir in", 1'b1, user_general_oe_n);
        chkb("shared ev", ext_rst, event_input_b);
        chkb("pv kept", event_output_c, position_valid_out);
        wr(ADDR_CONFIG, cfg(SEL_USER, 1'b1, FUNC_IN));
        idle(1);
        chkb("choice pulse", 1'b0, reset_pulse_oe_n);
        $display("test user pin done");
        end_of_test();
    end
endmodule : multiplexed_io_pin_selector_bench
